// ===== inc/aer_ue_defines.vh
`ifndef AER_UE_DEFINES_VH
`define AER_UE_DEFINES_VH

// Configuration space offsets of the uncorrectable error group.
`define AER_UE_STATUS_OFS 12'h104
`define AER_UE_MASK_OFS 12'h108
`define AER_UE_SEV_OFS 12'h10C

// Field positions.
`define AER_UE_BIT_UNUSED0 0
`define AER_UE_BIT_LINK_PROTOCOL 4
`define AER_UE_BIT_SURPRISE_DOWN 5
`define AER_UE_BIT_POISONED 12
`define AER_UE_BIT_FLOW_CONTROL 13
`define AER_UE_BIT_COMPLETION_TIMEOUT 14
`define AER_UE_BIT_COMPLETER_ABORT 15
`define AER_UE_BIT_UNEXPECTED_COMPLETION 16
`define AER_UE_BIT_RECEIVER_OVERFLOW 17
`define AER_UE_BIT_MALFORMED 18
`define AER_UE_BIT_ECRC 19
`define AER_UE_BIT_UNSUPPORTED_REQUEST 20

// Bits that software may write in the mask and severity registers.
`define AER_UE_WRITABLE 32'h001F3031
// Bits that carry real error events.
`define AER_UE_EVENT_BITS 32'h001F3030

// Reset values.
`define AER_UE_MASK_RESET 32'h00000000
`define AER_UE_SEV_RESET 32'h00062030
`define AER_UE_STATUS_RESET 32'h00000000

`endif

// ===== src/aer_sticky_field.v
`timescale 1ns/1ps
`include "aer_ue_defines.vh"

// Sticky read/write register; only the sticky reset returns it to default.
module aer_sticky_field #(
	parameter WIDTH = 32,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}},
	parameter [WIDTH-1:0] WRITABLE = {WIDTH{1'b1}}
)(
	input wire clk,
	input wire sticky_nrst,
	input wire wr,
	input wire [WIDTH-1:0] lane_bits,
	input wire [WIDTH-1:0] wdata,
	output wire [WIDTH-1:0] q
);

	reg [WIDTH-1:0] value_reg;
	wire [WIDTH-1:0] take;

	assign take = lane_bits & WRITABLE;
	assign q = value_reg;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1)
		begin : bit_cell
			always @(posedge clk)
			begin
				if (!sticky_nrst)
					value_reg[g] <= RESET_VALUE[g];
				else if (wr && take[g])
					value_reg[g] <= wdata[g];
			end
		end
	endgenerate

endmodule

// ===== src/aer_lowest_event.v
`timescale 1ns/1ps

// Finds the lowest-numbered set bit of a vector.
module aer_lowest_event #(
	parameter WIDTH = 32,
	parameter IDX_W = 5
)(
	input wire [WIDTH-1:0] vec,
	output reg any,
	output reg [IDX_W-1:0] idx
);

	integer i;

	always @*
	begin
		any = 1'b0;
		idx = {IDX_W{1'b0}};
		for (i = WIDTH - 1; i >= 0; i = i - 1)
		begin
			if (vec[i])
			begin
				any = 1'b1;
				idx = i[IDX_W-1:0];
			end
		end
	end

endmodule

// ===== src/aer_uncorrectable_mask_severity.v
`timescale 1ns/1ps
`include "aer_ue_defines.vh"

// Operation
// - A set mask bit keeps the matching status bit from being logged.
// - Masked errors never enter the first-error log.
// - Masked errors never produce an error report upstream.
// - Mask bits 4 and 5 gate link-protocol and surprise-down errors, writable.
// - Mask bits 12 and 13 gate poisoned and flow-control errors, writable.
// - Mask bits 16 to 20 gate completion through unsupported-request errors.
// - Mask bit 14 is read-only zero.
// - Mask bit 15 is read-only zero.
// - Bit 0 of mask and severity is plain storage resetting to zero.
// - Severity only matters for unmasked events.
// - Unmasked event with severity one is reported fatal.
// - Unmasked event with severity zero is reported non-fatal.
// - Severity bits 4 and 5 are writable and reset to one.
// - Severity bit 13 is writable and resets to one.
// - Severity bit 12 is writable and resets to zero.
// - Severity bits 14 and 15 are read-only zero.
// - Status bits set on event, cleared by writing one.
module aer_uncorrectable_mask_severity #(
	parameter DATA_W = 32,
	parameter ADDR_W = 12
)(
	input wire clk,
	input wire nrst,
	input wire sticky_nrst,
	input wire [ADDR_W-1:0] cfg_addr,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [DATA_W-1:0] cfg_wdata,
	input wire [3:0] cfg_be,
	input wire [DATA_W-1:0] err_event,
	output reg [DATA_W-1:0] cfg_rdata,
	output reg cfg_ack,
	output reg report_fatal,
	output reg report_nonfatal,
	output reg first_err_valid,
	output reg [4:0] first_err_ptr
);

	// Expands byte enables to a bit mask.
	function [31:0] lane_expand;
		input [3:0] be;
		begin
			lane_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	// True when the access addresses the given register.
	function hit;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			hit = (addr[11:2] == ofs[11:2]);
		end
	endfunction

	localparam SEL_NONE = 2'b00;
	localparam SEL_STATUS = 2'b01;
	localparam SEL_MASK = 2'b10;
	localparam SEL_SEV = 2'b11;

	localparam LOG_EMPTY = 1'b0;
	localparam LOG_HELD = 1'b1;

	localparam [31:0] EVENT_MASK = `AER_UE_EVENT_BITS;
	localparam [31:0] STATUS_INIT = `AER_UE_STATUS_RESET;

	// Names the register that an access selects.
	function [1:0] reg_select;
		input [11:0] addr;
		begin
			if (hit(addr, `AER_UE_STATUS_OFS))
				reg_select = SEL_STATUS;
			else if (hit(addr, `AER_UE_MASK_OFS))
				reg_select = SEL_MASK;
			else if (hit(addr, `AER_UE_SEV_OFS))
				reg_select = SEL_SEV;
			else
				reg_select = SEL_NONE;
		end
	endfunction

	wire [31:0] lanes;
	wire [1:0] sel;
	wire mask_wr;
	wire sev_wr;
	wire status_wr;
	wire [31:0] mask_q;
	wire [31:0] sev_q;
	wire [31:0] status_view;
	wire [31:0] mask_view;
	wire [31:0] sev_view;
	wire [31:0] live;
	wire [31:0] clear_req;
	wire [31:0] status_next;
	wire [31:0] fatal_hits;
	wire [31:0] nonfatal_hits;
	wire live_any;
	wire [4:0] live_idx;
	reg [31:0] status_reg;
	reg [31:0] rdata_next;
	reg log_state_reg;
	reg log_state_next;
	reg [4:0] log_ptr_next;

	// Decodes the register selected by each access.
	assign lanes = lane_expand(cfg_be);
	assign sel = reg_select(cfg_addr);
	assign mask_wr = cfg_wr && (sel == SEL_MASK);
	assign sev_wr = cfg_wr && (sel == SEL_SEV);
	assign status_wr = cfg_wr && (sel == SEL_STATUS);
	assign clear_req = cfg_wdata & lanes & {32{status_wr}};

	// Writable set covers bits 0, 4, 5, 12, 13 and 16 to 20 only.
	aer_sticky_field #(
		.WIDTH(32),
		.RESET_VALUE(`AER_UE_MASK_RESET),
		.WRITABLE(`AER_UE_WRITABLE)
	) mask_field (
		.clk(clk),
		.sticky_nrst(sticky_nrst),
		.wr(mask_wr),
		.lane_bits(lanes),
		.wdata(cfg_wdata),
		.q(mask_q)
	);

	aer_sticky_field #(
		.WIDTH(32),
		.RESET_VALUE(`AER_UE_SEV_RESET),
		.WRITABLE(`AER_UE_WRITABLE)
	) sev_field (
		.clk(clk),
		.sticky_nrst(sticky_nrst),
		.wr(sev_wr),
		.lane_bits(lanes),
		.wdata(cfg_wdata),
		.q(sev_q)
	);

	// Exposes only the implemented bits on readback.
	assign status_view = status_reg & EVENT_MASK;
	assign mask_view = mask_q & `AER_UE_WRITABLE;
	assign sev_view = sev_q & `AER_UE_WRITABLE;

	genvar s;
	generate
		for (s = 0; s < 32; s = s + 1)
		begin : status_cell
			// Only real event bits that are not masked pass on.
			assign live[s] = err_event[s] & ~mask_q[s] &
				EVENT_MASK[s];
			assign fatal_hits[s] = live[s] & sev_q[s];
			assign nonfatal_hits[s] = live[s] & ~sev_q[s];
			// Set wins over a same-cycle write-one-to-clear.
			assign status_next[s] = live[s] |
				(status_reg[s] & ~clear_req[s]);
			always @(posedge clk)
			begin
				if (!sticky_nrst)
					status_reg[s] <= STATUS_INIT[s];
				else
					status_reg[s] <= status_next[s] & EVENT_MASK[s];
			end
		end
	endgenerate

	aer_lowest_event #(
		.WIDTH(32),
		.IDX_W(5)
	) first_pick (
		.vec(live),
		.any(live_any),
		.idx(live_idx)
	);

	// First-error log: captures the lowest live event while empty.
	always @*
	begin
		log_state_next = log_state_reg;
		log_ptr_next = first_err_ptr;
		case (log_state_reg)
			LOG_EMPTY:
			begin
				if (live_any)
				begin
					log_state_next = LOG_HELD;
					log_ptr_next = live_idx;
				end
			end
			LOG_HELD:
			begin
				// A cleared entry makes room for an event of this cycle.
				if (!status_next[first_err_ptr])
				begin
					if (live_any)
						log_ptr_next = live_idx;
					else
						log_state_next = LOG_EMPTY;
				end
			end
			default:
			begin
				log_state_next = LOG_EMPTY;
			end
		endcase
	end

	// Registers the log state and its visible copy.
	always @(posedge clk)
	begin
		if (!sticky_nrst)
		begin
			log_state_reg <= LOG_EMPTY;
			first_err_valid <= 1'b0;
			first_err_ptr <= 5'h00;
		end
		else
		begin
			log_state_reg <= log_state_next;
			first_err_valid <= (log_state_next == LOG_HELD);
			first_err_ptr <= log_ptr_next;
		end
	end

	// Pulses one report per cycle with a live fatal event.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			report_fatal <= 1'b0;
		end
		else
		begin
			report_fatal <= |fatal_hits;
		end
	end

	// Pulses one report per cycle with a live non-fatal event.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			report_nonfatal <= 1'b0;
		end
		else
		begin
			report_nonfatal <= |nonfatal_hits;
		end
	end

	// Selects the read data of the addressed register.
	always @*
	begin
		rdata_next = 32'h00000000;
		case (sel)
			SEL_STATUS:
			begin
				rdata_next = status_view;
			end
			SEL_MASK:
			begin
				rdata_next = mask_view;
			end
			SEL_SEV:
			begin
				rdata_next = sev_view;
			end
			default:
			begin
				rdata_next = 32'h00000000;
			end
		endcase
	end

	// Acknowledges every access one cycle after its strobe.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			cfg_ack <= 1'b0;
		end
		else
		begin
			cfg_ack <= cfg_rd | cfg_wr;
		end
	end

	// Holds the read data until the next read.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			cfg_rdata <= 32'h00000000;
		end
		else if (cfg_rd)
		begin
			cfg_rdata <= rdata_next;
		end
	end

endmodule

// ===== test/aer_ums_chk.sv
`timescale 1ns/1ps
module aer_ums_chk(
	input wire clk,
	input wire nrst,
	input wire sticky_nrst,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [31:0] err_event,
	input wire [31:0] cfg_rdata,
	input wire cfg_ack,
	input wire report_fatal,
	input wire report_nonfatal,
	input wire first_err_valid,
	input wire [4:0] first_err_ptr
);
wire [31:0] live = err_event & 32'h001F3030;
reg [31:0] live_q;
always @(posedge clk)
	live_q <= live;
default clocking @(posedge clk); endclocking
default disable iff (!nrst || !sticky_nrst);
property p_rsv; cfg_ack && $past(cfg_rd) |-> !(cfg_rdata & 32'hFFE0CFCE); endproperty
property p_quiet; live == 32'h0 |=> !report_fatal && !report_nonfatal; endproperty
property p_cause; report_fatal || report_nonfatal |-> $past(live) != 0; endproperty
property p_ptr; $rose(first_err_valid) |-> live_q[first_err_ptr]; endproperty
property p_ptr_ok; first_err_valid |-> (32'h001F3030 >> first_err_ptr) & 1; endproperty
property p_log; first_err_valid && !cfg_wr |=> first_err_valid; endproperty
property p_ack; cfg_rd || cfg_wr |=> cfg_ack; endproperty
property p_ack_only; !(cfg_rd || cfg_wr) |=> !cfg_ack; endproperty
a_rsv: assert property (p_rsv) else $error("bad read bits");
a_quiet: assert property (p_quiet) else $error("stray report");
a_cause: assert property (p_cause) else $error("no cause");
a_ptr: assert property (p_ptr) else $error("bad log");
a_ptr_ok: assert property (p_ptr_ok) else $error("bad ptr");
a_log: assert property (p_log) else $error("log lost");
a_ack: assert property (p_ack) else $error("no ack");
a_ack_only: assert property (p_ack_only) else $error("stray ack");
c_fatal: cover property (report_fatal);
c_nonfatal: cover property (report_nonfatal);
c_log: cover property ($rose(first_err_valid));
endmodule
bind aer_uncorrectable_mask_severity aer_ums_chk u_chk(.clk, .nrst,
	.sticky_nrst, .cfg_wr, .cfg_rd, .err_event, .cfg_rdata, .cfg_ack,
	.report_fatal, .report_nonfatal, .first_err_valid, .first_err_ptr);

// ===== test/rc_model.sv
`timescale 1ns/1ps
// Counts error messages arriving upstream.
module rc_model(
	input wire clk,
	input wire report_fatal,
	input wire report_nonfatal,
	output int ff,
	output int nf
);
initial
	{ff, nf} = 0;
always @(posedge clk)
begin
	ff <= ff + (report_fatal === 1'b1);
	nf <= nf + (report_nonfatal === 1'b1);
end
endmodule

// ===== test/test_aer_uncorrectable_mask_severity.sv
`timescale 1ns/1ps
module test_aer_uncorrectable_mask_severity;
logic clk = 0, nrst = 0, sticky_nrst = 0, cfg_wr = 0, cfg_rd = 0;
logic [11:0] cfg_addr = 0;
logic [31:0] cfg_wdata = 0, err_event = 0;
logic [3:0] cfg_be = 4'hF;
wire [31:0] cfg_rdata;
wire cfg_ack, report_fatal, report_nonfatal, first_err_valid;
wire [4:0] first_err_ptr;
int err_total = 0, checks = 0, ff, nf;
logic [75:0] rows [6] = '{
	{12'h108, 32'hFFFFFFFF, 32'h001F3031},
	{12'h10C, 32'hFFFFFFFF, 32'h001F3031},
	{12'h10C, 32'h00000000, 32'h00000000},
	{12'h200, 32'hFFFFFFFF, 32'h00000000},
	{12'h10C, 32'h00062030, 32'h00062030},
	{12'h108, 32'h00001000, 32'h00001000}};
aer_uncorrectable_mask_severity DUT(.clk, .nrst, .sticky_nrst, .cfg_addr,
	.cfg_wr, .cfg_rd, .cfg_wdata, .cfg_be, .err_event, .cfg_rdata, .cfg_ack,
	.report_fatal, .report_nonfatal, .first_err_valid, .first_err_ptr);
rc_model rc(.clk, .report_fatal, .report_nonfatal, .ff, .nf);
initial
	forever #5 clk = ~clk;
task chk(string n, logic [31:0] e, logic [31:0] s);
	checks++;
	if (s !== e)
	begin
		$display("[FAIL] %s exp %h got %h", n, e, s);
		err_total++;
	end
endtask
task rw(logic [11:0] a, logic [31:0] d, logic [31:0] e);
	@(negedge clk) {cfg_addr, cfg_wdata, cfg_wr} = {a, d, 1'b1};
	@(negedge clk) {cfg_wr, cfg_rd} = 2'b01;
	@(negedge clk) cfg_rd = 0;
	chk("ack", 1, cfg_ack);
	chk("rdata", e, cfg_rdata);
endtask
task ev(int b, logic f, logic n);
	@(negedge clk) err_event = 32'h1 << b;
	@(negedge clk) err_event = 0;
	chk("fatal", f, report_fatal);
	chk("nonfatal", n, report_nonfatal);
endtask
task end_sim;
	$display("checks %0d errors %0d", checks, err_total);
	if (err_total == 0 && checks > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
initial
begin
	#50000;
	err_total++;
	end_sim;
end
initial
begin
	repeat (16) @(posedge clk);
	@(negedge clk) {nrst, sticky_nrst} = 2'b11;
	foreach (rows[i]) rw(rows[i][75:64], rows[i][63:32], rows[i][31:0]);
	$display("table done");
	@(negedge clk) nrst = 0;
	@(negedge clk) nrst = 1;
	cfg_be = 0;
	rw(12'h108, 32'hFFFFFFFF, 32'h00001000);
	ev(12, 0, 0);
	chk("valid", 0, first_err_valid);
	@(negedge clk) sticky_nrst = 0;
	@(negedge clk) sticky_nrst = 1;
	rw(12'h108, 32'hFFFFFFFF, 32'h00000000);
	rw(12'h10C, 32'hFFFFFFFF, 32'h00062030);
	cfg_be = 4'hF;
	$display("sticky done");
	ev(12, 0, 1);
	ev(13, 1, 0);
	ev(14, 0, 0);
	chk("ptr", 12, first_err_ptr);
	rw(12'h104, 32'h00001000, 32'h00002000);
	chk("valid", 0, first_err_valid);
	$display("events done");
	ev(4, 1, 0);
	chk("ptr", 4, first_err_ptr);
	ev(5, 1, 0);
	ev(16, 0, 1);
	ev(17, 1, 0);
	ev(20, 0, 1);
	ev(0, 0, 0);
	rw(12'h108, 32'h00040000, 32'h00040000);
	ev(18, 0, 0);
	rw(12'h104, 32'h00000000, 32'h00132030);
	@(negedge clk)
	begin
		{cfg_addr, cfg_wdata, cfg_wr} = {12'h104, 32'h00002000, 1'b1};
		err_event = 32'h00002000;
	end
	@(negedge clk) {cfg_wr, cfg_rd, err_event} = {2'b01, 32'h00000000};
	@(negedge clk) cfg_rd = 0;
	chk("set wins", 32'h00132030, cfg_rdata);
	rw(12'h104, 32'h00132030, 32'h00000000);
	chk("valid", 0, first_err_valid);
	chk("fatal cnt", 5, ff);
	chk("nonfatal cnt", 3, nf);
	$display("corner done");
	end_sim;
end
endmodule
